//--- hw/anr_cfg.svh
// constants of the asynchronous nor flash access controller
// assumes inclusion by its bare name from package and modules
`ifndef ANR_CFG_SVH
`define ANR_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define ANR_AW 26
`define ANR_DW 16
`define ANR_CW 10
`define ANR_PAW 12

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ANR_OFS_CTL 12'h000
`define ANR_OFS_TIM 12'h004
`define ANR_OFS_WTIM 12'h008
`define ANR_CTL_MASK 32'h0000_c201
`define ANR_TIM_MASK 32'h300f_ffff
`define ANR_CTL_RST 32'h0000_0000
`define ANR_TIM_RST 32'h000f_ffff

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define ANR_BIT_BANK_EN 0
`define ANR_BIT_WAIT_POL 9
`define ANR_BIT_EXT_MODE 14
`define ANR_BIT_WAIT_EN 15
`define ANR_F_AMODE 29:28
`define ANR_F_BUSL 19:16
`define ANR_F_DATA_SETUP_TIME 15:8
`define ANR_F_ADDRESS_SETUP_TIME 3:0
`define ANR_AMODE_B 2'h1
`define ANR_AMODE_C 2'h2

// ----------------------------------------------------------------
// phase lengths in system clock cycles
// ----------------------------------------------------------------
`define ANR_RD_EXTRA 10'h003
`define ANR_WR_EXTRA 10'h001
`define ANR_ONE 10'h001

`endif

//--- hw/anr_pkg.sv
// types of the asynchronous nor flash access controller
// assumes anr_cfg.svh on the include path
`include "anr_cfg.svh"

package anr_pkg;

    // ------------------------------------------------------------
    // states and timing sets
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_TURN
    } anr_state_t;

    typedef struct packed {
        logic [1:0] amode;
        logic [3:0] busl;
        logic [7:0] data_setup_time;
        logic [3:0] address_setup_time;
    } anr_tim_t;

    typedef struct packed {
        logic [`ANR_CW-1:0] cnt;
    } anr_cnt_st_t;

    typedef struct packed {
        anr_state_t state;
        logic [31:0] ctl;
        logic [31:0] tim;
        logic [31:0] wtim;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic req_ready;
        logic resp_valid;
        logic [`ANR_DW-1:0] rdata;
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic [`ANR_AW-1:0] addr;
        logic [`ANR_DW-1:0] dout;
        logic doe;
        logic is_write;
        logic toggle;
        anr_tim_t at;
    } anr_ctl_st_t;

endpackage

//--- hw/anr_phase_cnt.sv
// phase down-counter of the nor flash access controller
// assumes load and hold come from the controller state machine
`timescale 1ns/10ps
`include "anr_cfg.svh"

module anr_phase_cnt (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [`ANR_CW-1:0] load_val,
    input wire logic hold,
    output logic [`ANR_CW-1:0] cnt
);

    anr_pkg::anr_cnt_st_t s_r;
    anr_pkg::anr_cnt_st_t s_nxt;

    // ------------------------------------------------------------
    // count
    // ------------------------------------------------------------
    // hold freezes the count, so a stretched phase resumes where it stood
    always_comb begin
        s_nxt = s_r;
        if (load) begin
            s_nxt.cnt = load_val;
        end else if (!hold && s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - `ANR_ONE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cnt = s_r.cnt;

endmodule // anr_phase_cnt

//--- hw/anr_ctrl.sv
// asynchronous nor flash access controller with apb registers
// assumes a synchronous request port and pins sampled on pclk
//
// Contract
// - read data phase lasts data setup plus three
// - separate-set write data phase lasts setup plus one
// - turnaround idle between chip select high and low
// - extended bit picks mode 2, or mode b or c by the access mode field
// - primary set: both in mode 2, reads in b and c
// - mode b and c writes use independent write set
// - extended off: one shared timing set
// - wait polarity counts only with wait enable
// - active wait stretches data setup phase
// - extended on: reads primary, writes write set
`timescale 1ns/10ps
`include "anr_cfg.svh"

module anr_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ANR_PAW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [`ANR_AW-1:0] req_addr,
    input wire logic [`ANR_DW-1:0] req_wdata,
    output logic req_ready,
    output logic resp_valid,
    output logic [`ANR_DW-1:0] resp_rdata,
    output logic chip_select_n,
    output logic oe_n,
    output logic we_n,
    output logic [`ANR_AW-1:0] mem_addr,
    input wire logic [`ANR_DW-1:0] mem_data_in,
    output logic [`ANR_DW-1:0] mem_data_out,
    output logic mem_data_oe,
    input wire logic wait_input_n
);

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    function automatic logic [1:0] reg_index(input logic [`ANR_PAW-1:0] a);
        logic [1:0] idx;
        idx = 2'h3;
        if (a == `ANR_OFS_CTL) begin
            idx = 2'h0;
        end else if (a == `ANR_OFS_TIM) begin
            idx = 2'h1;
        end else if (a == `ANR_OFS_WTIM) begin
            idx = 2'h2;
        end
        return idx;
    endfunction

    function automatic anr_pkg::anr_tim_t tim_fields(input logic [31:0] w);
        anr_pkg::anr_tim_t t;
        t.amode = w[`ANR_F_AMODE];
        t.busl = w[`ANR_F_BUSL];
        t.data_setup_time = w[`ANR_F_DATA_SETUP_TIME];
        t.address_setup_time = w[`ANR_F_ADDRESS_SETUP_TIME];
        return t;
    endfunction

    anr_pkg::anr_ctl_st_t s_r;
    anr_pkg::anr_ctl_st_t s_nxt;

    logic ld;
    logic [`ANR_CW-1:0] ld_val;
    logic hold;
    logic [`ANR_CW-1:0] cnt;

    anr_phase_cnt anr_phase_cnt_i (
        .pclk(pclk),
        .presetn(presetn),
        .load(ld),
        .load_val(ld_val),
        .hold(hold),
        .cnt(cnt)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic ext;
        logic wait_act;
        logic [1:0] idx;
        anr_pkg::anr_tim_t rt;
        anr_pkg::anr_tim_t wt;
        anr_pkg::anr_tim_t it;
        s_nxt = s_r;
        ld = 1'b0;
        ld_val = '0;
        hold = 1'b0;
        ext = s_r.ctl[`ANR_BIT_EXT_MODE];
        idx = reg_index(paddr);
        rt = tim_fields(s_r.tim);
        wt = ext ? tim_fields(s_r.wtim) : rt;
        it = req_write ? wt : rt;
        wait_act = 1'b0;
        if (s_r.ctl[`ANR_BIT_WAIT_EN]) begin
            wait_act = s_r.ctl[`ANR_BIT_WAIT_POL] ? wait_input_n : ~wait_input_n;
        end

        // apb: one wait state, write lands on the pready edge
        s_nxt.pready = psel & penable & ~s_r.pready;
        if (psel && penable && !s_r.pready) begin
            s_nxt.pslverr = (idx == 2'h3);
            case (idx)
                2'h0: s_nxt.prdata = s_r.ctl;
                2'h1: s_nxt.prdata = s_r.tim;
                2'h2: s_nxt.prdata = s_r.wtim;
                default: s_nxt.prdata = 32'h0000_0000;
            endcase
        end
        if (psel && penable && s_r.pready && pwrite) begin
            case (idx)
                2'h0: s_nxt.ctl = pwdata & `ANR_CTL_MASK;
                2'h1: s_nxt.tim = pwdata & `ANR_TIM_MASK;
                2'h2: s_nxt.wtim = pwdata & `ANR_TIM_MASK;
                default: s_nxt.ctl = s_r.ctl;
            endcase
        end

        s_nxt.resp_valid = 1'b0;
        case (s_r.state)
            anr_pkg::ST_IDLE: begin
                if (req_valid && s_r.req_ready) begin
                    // timing set latched whole, so a mid-access write waits
                    s_nxt.at = it;
                    s_nxt.is_write = req_write;
                    s_nxt.addr = req_addr;
                    s_nxt.dout = req_wdata;
                    s_nxt.toggle = ext & (it.amode == `ANR_AMODE_C);
                    s_nxt.cs_n = 1'b0;
                    s_nxt.oe_n = req_write | s_nxt.toggle;
                    s_nxt.state = anr_pkg::ST_ADDR;
                    ld = 1'b1;
                    ld_val = (it.address_setup_time == 4'h0) ? '0 : {6'h00, it.address_setup_time - 4'h1};
                end
            end
            anr_pkg::ST_ADDR: begin
                if (cnt == '0) begin
                    s_nxt.state = anr_pkg::ST_DATA;
                    s_nxt.we_n = ~s_r.is_write;
                    s_nxt.oe_n = s_r.is_write;
                    s_nxt.doe = s_r.is_write;
                    ld = 1'b1;
                    if (s_r.is_write) begin
                        ld_val = {2'b00, s_r.at.data_setup_time} + `ANR_WR_EXTRA - `ANR_ONE;
                    end else begin
                        ld_val = {2'b00, s_r.at.data_setup_time} + `ANR_RD_EXTRA - `ANR_ONE;
                    end
                end
            end
            anr_pkg::ST_DATA: begin
                hold = wait_act;
                if (cnt == '0 && !wait_act) begin
                    if (!s_r.is_write) begin
                        s_nxt.rdata = mem_data_in;
                    end
                    s_nxt.resp_valid = 1'b1;
                    s_nxt.cs_n = 1'b1;
                    s_nxt.oe_n = 1'b1;
                    s_nxt.we_n = 1'b1;
                    s_nxt.doe = 1'b0;
                    if (s_r.at.busl == 4'h0) begin
                        s_nxt.state = anr_pkg::ST_IDLE;
                    end else begin
                        s_nxt.state = anr_pkg::ST_TURN;
                        ld = 1'b1;
                        ld_val = {6'h00, s_r.at.busl - 4'h1};
                    end
                end
            end
            anr_pkg::ST_TURN: begin
                if (cnt == '0) begin
                    s_nxt.state = anr_pkg::ST_IDLE;
                end
            end
            default: begin
                s_nxt.state = anr_pkg::ST_IDLE;
            end
        endcase
        s_nxt.req_ready = (s_nxt.state == anr_pkg::ST_IDLE) & s_nxt.ctl[`ANR_BIT_BANK_EN];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.state <= anr_pkg::ST_IDLE;
            s_r.ctl <= `ANR_CTL_RST;
            s_r.tim <= `ANR_TIM_RST;
            s_r.wtim <= `ANR_TIM_RST;
            s_r.cs_n <= 1'b1;
            s_r.oe_n <= 1'b1;
            s_r.we_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign req_ready = s_r.req_ready;
    assign resp_valid = s_r.resp_valid;
    assign resp_rdata = s_r.rdata;
    assign chip_select_n = s_r.cs_n;
    assign oe_n = s_r.oe_n;
    assign we_n = s_r.we_n;
    assign mem_addr = s_r.addr;
    assign mem_data_out = s_r.dout;
    assign mem_data_oe = s_r.doe;

endmodule // anr_ctrl

//--- tb/anr_flash_model.sv
// behavioural nor flash at the far side of the controller
// assumes pins sampled on pclk; wait driven only when asked
`timescale 1ns/10ps
`include "anr_cfg.svh"
module anr_flash_model (
    input wire logic pclk,
    input wire logic chip_select_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [`ANR_AW-1:0] mem_addr,
    input wire logic [`ANR_DW-1:0] mem_data_out,
    input wire logic stall,
    input wire logic pol,
    output logic [`ANR_DW-1:0] mem_data_in,
    output logic wait_input_n
);
    logic [`ANR_DW-1:0] mem [256];
    logic [2:0] wcnt;
    logic act;
    // wait is bounded so a stretched access still ends
    assign act = stall && (!we_n || !oe_n) && wcnt < 3'h3;
    always @(posedge pclk) begin
        if (!chip_select_n && !we_n) mem[mem_addr[7:0]] <= mem_data_out;
        // released bus toggles so stale data never matches
        if (!chip_select_n && !oe_n) mem_data_in <= mem[mem_addr[7:0]];
        else mem_data_in <= ~mem_data_in;
        wcnt <= chip_select_n ? 3'h0 : wcnt + {2'h0, act};
        wait_input_n <= act ? pol : !pol;
    end
endmodule // anr_flash_model

//--- tb/anr_ctrl_chk.sv
// port assertions of the nor flash controller
// assumes binding onto anr_ctrl
`timescale 1ns/10ps
module anr_ctrl_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire logic chip_select_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic mem_data_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("apb wait state wrong");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than a cycle");
    resp_pulse_a: assert property (resp_valid |=> !resp_valid)
        else $error("resp_valid longer than a cycle");
    resp_release_a: assert property (resp_valid |-> chip_select_n && oe_n && we_n)
        else $error("strobes held at access end");
    turn_gap_a: assert property ($rose(chip_select_n) |=> chip_select_n)
        else $error("no turnaround gap");
    strobe_excl_a: assert property (!(!oe_n && !we_n))
        else $error("both strobes low");
    write_drive_a: assert property (!we_n |-> !chip_select_n && mem_data_oe)
        else $error("write strobe without bus");
    busy_ready_a: assert property (!chip_select_n |-> !req_ready)
        else $error("ready during access");
    cover property (!we_n);
    cover property (!oe_n && !chip_select_n);
    cover property (pslverr && pready);
endmodule // anr_ctrl_chk
bind anr_ctrl anr_ctrl_chk anr_ctrl_chk_i (.pclk, .presetn, .psel, .penable, .pready,
    .pslverr, .req_ready, .resp_valid, .chip_select_n, .oe_n, .we_n, .mem_data_oe);

//--- tb/anr_ctrl_tb_top.sv
// self-checking bench of the nor flash controller
// assumes anr_ctrl, the flash model and the bound checker
`timescale 1ns/10ps
`include "anr_cfg.svh"
module anr_ctrl_tb_top;
    logic pclk, presetn, psel, penable, pwrite, req_valid, req_write, stall, mpol;
    logic pready, pslverr, req_ready, resp_valid, cs_n, oe_n, we_n, doe, e, x, wait_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, tim, wtim;
    logic [25:0] req_addr, maddr;
    logic [15:0] req_wdata, rdata, din, dout, d, r;
    int fail_count, samples_checked, seed, i, ncs, nst, hi, gap, bl;
    logic [3:0] wt [4] = '{4'h0, 4'h4, 4'h9, 4'hf};
    anr_ctrl anr_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .req_valid, .req_write, .req_addr, .req_wdata,
        .req_ready, .resp_valid, .resp_rdata(rdata), .chip_select_n(cs_n), .oe_n, .we_n,
        .mem_addr(maddr), .mem_data_in(din), .mem_data_out(dout), .mem_data_oe(doe),
        .wait_input_n(wait_n));
    anr_flash_model anr_flash_model_i (.pclk, .chip_select_n(cs_n), .oe_n, .we_n,
        .mem_addr(maddr), .mem_data_out(dout), .stall, .pol(mpol), .mem_data_in(din),
        .wait_input_n(wait_n));
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (cs_n) hi++;
        else begin
            if (hi > 0) gap = hi;
            hi = 0;
        end
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task test_done;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] ex, input logic [31:0] g);
        samples_checked++;
        if (g !== ex) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", s, ex, g);
        end
    endtask
    task wt_end(input int n, input int lim);
        if (n >= lim) begin
            chk("timeout", 0, 1);
            test_done();
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] dd);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dd;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        wt_end(n, 20);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        // one idle edge, so the next call never re-raises psel in this step
        @(posedge pclk);
    endtask
    task acc(input logic w, input logic [25:0] a, input logic [15:0] dd);
        int n;
        req_valid <= 1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= dd;
        n = 0;
        do begin @(posedge pclk); n++; end while (req_ready !== 1'b1 && n < 50);
        wt_end(n, 50);
        req_valid <= 0;
        {n, ncs, nst} = 0;
        do begin
            @(posedge pclk);
            n++;
            ncs += !cs_n;
            nst += w ? !we_n : !oe_n;
        end while (resp_valid !== 1'b1 && n < 600);
        wt_end(n, 600);
        r = rdata;
    endtask
    function automatic logic [31:0] rt();
        return {2'h0, 2'h1 + 2'($random(seed) & 1), 8'h0, 4'($random(seed) & 3),
            8'($random(seed) & 7), 4'h0, 4'($random(seed) & 3)};
    endfunction
    // cycles of chip select (st=0) or data strobe (st=1)
    function automatic int el(logic w, logic m, logic [31:0] t, logic [31:0] u, logic st);
        logic [31:0] s;
        int a, dd;
        s = (w && m) ? u : t;
        a = (s[3:0] == 4'h0) ? 1 : s[3:0];
        dd = s[15:8] + (w ? 1 : 3);
        return (st && (w || (m && s[29:28] == 2'h2))) ? dd : a + dd;
    endfunction
    initial begin
        {psel, penable, pwrite, req_valid, req_write, stall, mpol, presetn} = 0;
        {paddr, pwdata, req_addr, req_wdata, hi, gap} = 0;
        seed = 69;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk("ready_off", 0, req_ready);
        apb(0, 12'h000, 0);
        chk("ctl_rst", `ANR_CTL_RST, q);
        for (i = 4; i < 12; i += 4) begin
            apb(0, 12'(i), 0);
            chk("tim_rst", `ANR_TIM_RST, q);
        end
        apb(1, 12'h00c, 32'hffff_ffff);
        chk("unmapped", 1, e);
        apb(1, 12'h004, 32'hffff_ffff);
        apb(0, 12'h004, 0);
        chk("tim_mask", `ANR_TIM_MASK, q);
        $display("registers done");
        for (i = 0; i < 12; i++) begin
            x = 1'($random(seed));
            tim = rt();
            wtim = rt();
            if (i == 0) tim[15:8] = 8'hff;
            apb(1, 12'h000, {17'h0, x, 13'h0, 1'b1});
            apb(1, 12'h004, tim);
            apb(1, 12'h008, wtim);
            d = 16'($random(seed));
            bl = x ? wtim[19:16] : tim[19:16];
            acc(1, req_addr ^ 26'($random(seed)), d);
            chk("wr_cs", el(1, x, tim, wtim, 0), ncs);
            chk("wr_strobe", el(1, x, tim, wtim, 1), nst);
            acc(0, req_addr, 16'h0);
            chk("rd_data", {16'h0, d}, {16'h0, r});
            chk("rd_strobe", el(0, x, tim, wtim, 1), nst);
            chk("rd_cs", el(0, x, tim, wtim, 0), ncs);
            chk("turn", 1, gap > bl);
        end
        $display("modes done");
        stall <= 1;
        for (i = 0; i < 4; i++) begin
            mpol <= wt[i][1];
            apb(1, 12'h000, {16'h0, wt[i][3], 5'h0, wt[i][2], 8'h0, 1'b1});
            apb(1, 12'h004, 32'h0000_0201);
            acc(1, 26'h5, 16'h1);
            if (wt[i][0]) chk("wait_on", 1, nst > 3);
            else chk("wait_off", 3, nst);
        end
        $display("wait done");
        test_done();
    end
endmodule // anr_ctrl_tb_top
